// File: logic/uart_ext_pkg.sv
// constants for the uart modem and network extension registers
`default_nettype none
package uart_ext_pkg;
    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_MODEM_LINE_STATUS       = 32'hffff0718;
    localparam logic [31:0] ADDR_SCRATCH_BYTE            = 32'hffff071c;
    localparam logic [31:0] ADDR_NETWORK_ENABLE_CONTROL  = 32'hffff0720;
    localparam logic [31:0] ADDR_NETWORK_INTERRUPT_IDENT = 32'hffff0724;
    localparam logic [31:0] ADDR_FRACTIONAL_BAUD_DIVIDER = 32'hffff072c;
    localparam logic [31:0] ADDR_IRQ_STATUS              = 32'hffff0740;
    localparam logic [31:0] ADDR_IRQ_MASK                = 32'hffff0744;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_MODEM_LINE_STATUS       = 8'h00;
    localparam logic [7:0]  RST_SCRATCH_BYTE            = 8'h00;
    localparam logic [7:0]  RST_NETWORK_ENABLE_CONTROL  = 8'h04;
    localparam logic [7:0]  RST_NETWORK_INTERRUPT_IDENT = 8'h01;
    localparam logic [15:0] RST_FRACTIONAL_BAUD_DIVIDER = 16'h0000;
    localparam logic [1:0]  RST_IRQ                     = 2'h0;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int MLS_LEVEL_LSB        = 4;
    localparam int FBD_ENABLE_BIT       = 15;
    localparam int FBD_M_MSB            = 12;
    localparam int FBD_M_LSB            = 11;
    localparam int FBD_N_MSB            = 10;
    localparam int NEC_MODE_BIT         = 7;
    localparam int NEC_TX9_BIT          = 6;
    localparam int NEC_RX9_BIT          = 5;
    localparam int NEC_IRQ_EN_BIT       = 4;
    localparam int NEC_WORD9_BIT        = 3;
    localparam int NEC_DRIVE_BIT        = 2;
    localparam int NEC_POLARITY_BIT     = 1;
    localparam int NEC_MARKER_BIT       = 0;
    localparam int IRQ_MODEM_BIT        = 0;
    localparam int IRQ_NETWORK_BIT      = 1;
    // ------------------------------------------------------------------
    // codes
    // ------------------------------------------------------------------
    localparam logic [2:0]  FRAC_M_ZERO_VALUE = 3'h4;
    localparam logic [2:0]  NET_IID_ADDRESS   = 3'h3;
endpackage : uart_ext_pkg
`default_nettype wire

// File: logic/uart_modem_network_ext.sv
// modem status, scratch, fractional divider and network mode registers on apb
`default_nettype none
// Operation
// - modem status bits 7..4 show carrier, ring, set ready, clear to send levels
// - bit 3 set on any carrier change, cleared by status read
// - bit 2 set on ring rising edge, cleared by status read
// - bit 1 set on any set ready change, cleared by status read
// - bit 0 set on any clear to send change, cleared by status read
// - eight bit read write scratch byte, also offered to network mode
// - divider bit 15 selects fractional baud generator, else integer generator
// - divider bits 12:11 give M, zero meaning four; bits 10:0 give N
// - network node operation only while network mode enable bit 7 set
// - no parity generation or checking in network mode
// - marker bit 0 sends characters as address when one, data when zero
// - bit 6 enables nine bit transmit, only with network mode
// - bit 5 enables nine bit receive, only with network mode
// - bit 3 picks nine bit word; software keeps nine bit transmit off
// - bit 2 drives serial output pin, else pin is three-stated
// - bit 4 gates network interrupt, bit 1 sets address interrupt polarity
// - read only network interrupt ident, top nibble zero, resets to 0x01
module uart_modem_network_ext (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        carrier_detect_i,
    input  wire logic        ring_indicator_i,
    input  wire logic        set_ready_i,
    input  wire logic        clear_to_send_i,
    input  wire logic        tx_serial_i,
    input  wire logic        rx_char_valid_i,
    input  wire logic        rx_ninth_bit_i,
    output logic             serial_out_pin_o,
    output logic             serial_out_pin_oe_o,
    output logic             frac_baud_enable_o,
    output logic      [2:0]  frac_m_o,
    output logic      [10:0] frac_n_o,
    output logic      [7:0]  scratch_o,
    output logic             network_mode_o,
    output logic             parity_disable_o,
    output logic             nine_bit_tx_o,
    output logic             nine_bit_rx_o,
    output logic             nine_bit_word_o,
    output logic             tx_ninth_bit_o,
    output logic             net_irq_o,
    output logic             irq_o
);
    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic        setup_rd;
    logic        acc_wr;
    logic        acc_rd;
    logic        addr_ok;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
        hit = (a == r);
    endfunction : hit

    assign setup_rd  = psel_i & ~penable_i & ~pwrite_i;
    assign acc_wr    = psel_i & penable_i & pwrite_i;
    assign acc_rd    = psel_i & penable_i & ~pwrite_i;
    assign addr_ok   = hit(paddr_i, uart_ext_pkg::ADDR_MODEM_LINE_STATUS)
                     | hit(paddr_i, uart_ext_pkg::ADDR_SCRATCH_BYTE)
                     | hit(paddr_i, uart_ext_pkg::ADDR_NETWORK_ENABLE_CONTROL)
                     | hit(paddr_i, uart_ext_pkg::ADDR_NETWORK_INTERRUPT_IDENT)
                     | hit(paddr_i, uart_ext_pkg::ADDR_FRACTIONAL_BAUD_DIVIDER)
                     | hit(paddr_i, uart_ext_pkg::ADDR_IRQ_STATUS)
                     | hit(paddr_i, uart_ext_pkg::ADDR_IRQ_MASK);
    // zero wait states; read data captured in setup so it is a flop
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~addr_ok;

    // ------------------------------------------------------------------
    // modem input synchronisers
    // ------------------------------------------------------------------
    // order {carrier, ring, set ready, clear to send}
    logic [3:0] pins;
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    logic [3:0] lvl_r;
    logic [3:0] lvl_nxt;
    logic [3:0] evt;

    assign pins = {carrier_detect_i, ring_indicator_i, set_ready_i, clear_to_send_i};

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s1_r  <= 4'h0;
            s2_r  <= 4'h0;
            s3_r  <= 4'h0;
            lvl_r <= 4'h0;
        end else begin
            s1_r  <= pins;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    // a level only counts once the second and third stage agree
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lvl
            assign lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
        end
    endgenerate

    assign evt = {lvl_nxt[3] ^ lvl_r[3],
                  lvl_nxt[2] & ~lvl_r[2],
                  lvl_nxt[1] ^ lvl_r[1],
                  lvl_nxt[0] ^ lvl_r[0]};

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [3:0]  mflag_r;
    logic [7:0]  scratch_r;
    logic [7:0]  nec_r;
    logic [15:0] div_r;
    logic        net_pend_r;
    logic [1:0]  ist_r;
    logic [1:0]  imask_r;
    logic [31:0] prdata_r;
    logic        rd_mls;
    logic        rd_iid;
    logic        net_evt;
    logic [1:0]  ievt;

    assign rd_mls  = acc_rd & hit(paddr_i, uart_ext_pkg::ADDR_MODEM_LINE_STATUS);
    assign rd_iid  = acc_rd & hit(paddr_i, uart_ext_pkg::ADDR_NETWORK_INTERRUPT_IDENT);

    // only the flags that were actually shown are cleared, new events win
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mflag_r <= uart_ext_pkg::RST_MODEM_LINE_STATUS[3:0];
        end else begin
            mflag_r <= (mflag_r & ~(rd_mls ? prdata_r[3:0] : 4'h0)) | evt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            scratch_r <= uart_ext_pkg::RST_SCRATCH_BYTE;
            nec_r     <= uart_ext_pkg::RST_NETWORK_ENABLE_CONTROL;
            div_r     <= uart_ext_pkg::RST_FRACTIONAL_BAUD_DIVIDER;
            imask_r   <= uart_ext_pkg::RST_IRQ;
        end else if (acc_wr) begin
            if (hit(paddr_i, uart_ext_pkg::ADDR_SCRATCH_BYTE))
                scratch_r <= pwdata_i[7:0];
            if (hit(paddr_i, uart_ext_pkg::ADDR_NETWORK_ENABLE_CONTROL))
                nec_r <= pwdata_i[7:0];
            if (hit(paddr_i, uart_ext_pkg::ADDR_FRACTIONAL_BAUD_DIVIDER))
                div_r <= {pwdata_i[15], 2'h0, pwdata_i[12:0]};
            if (hit(paddr_i, uart_ext_pkg::ADDR_IRQ_MASK))
                imask_r <= pwdata_i[1:0];
        end
    end

    // ------------------------------------------------------------------
    // network address interrupt
    // ------------------------------------------------------------------
    // address char is one whose ninth bit matches the chosen polarity
    assign net_evt = network_mode_o & nine_bit_rx_o & rx_char_valid_i
                   & (rx_ninth_bit_i == nec_r[uart_ext_pkg::NEC_POLARITY_BIT]);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            net_pend_r <= 1'b0;
        end else begin
            net_pend_r <= (net_pend_r & ~(rd_iid & ~prdata_r[0])) | net_evt;
        end
    end

    // ------------------------------------------------------------------
    // sticky interrupt status, write one to clear
    // ------------------------------------------------------------------
    assign ievt = {net_evt & nec_r[uart_ext_pkg::NEC_IRQ_EN_BIT], |evt};

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ist_r <= uart_ext_pkg::RST_IRQ;
        end else begin
            ist_r <= (ist_r & ~((acc_wr & hit(paddr_i, uart_ext_pkg::ADDR_IRQ_STATUS)) ? pwdata_i[1:0] : 2'h0))
                   | ievt;
        end
    end

    assign irq_o     = |(ist_r & imask_r);
    assign net_irq_o = net_pend_r & nec_r[uart_ext_pkg::NEC_IRQ_EN_BIT];

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            prdata_r <= 32'h0;
        end else if (setup_rd) begin
            prdata_r <= 32'h0;
            if (hit(paddr_i, uart_ext_pkg::ADDR_MODEM_LINE_STATUS))
                prdata_r[7:0] <= {lvl_r, mflag_r};
            else if (hit(paddr_i, uart_ext_pkg::ADDR_SCRATCH_BYTE))
                prdata_r[7:0] <= scratch_r;
            else if (hit(paddr_i, uart_ext_pkg::ADDR_NETWORK_ENABLE_CONTROL))
                prdata_r[7:0] <= nec_r;
            else if (hit(paddr_i, uart_ext_pkg::ADDR_NETWORK_INTERRUPT_IDENT))
                prdata_r[7:0] <= {4'h0, net_pend_r ? uart_ext_pkg::NET_IID_ADDRESS : 3'h0,
                                  ~net_pend_r};
            else if (hit(paddr_i, uart_ext_pkg::ADDR_FRACTIONAL_BAUD_DIVIDER))
                prdata_r[15:0] <= div_r;
            else if (hit(paddr_i, uart_ext_pkg::ADDR_IRQ_STATUS))
                prdata_r[1:0] <= ist_r;
            else if (hit(paddr_i, uart_ext_pkg::ADDR_IRQ_MASK))
                prdata_r[1:0] <= imask_r;
        end
    end
    assign prdata_o = prdata_r;

    // ------------------------------------------------------------------
    // controls toward the uart core
    // ------------------------------------------------------------------
    assign frac_baud_enable_o = div_r[uart_ext_pkg::FBD_ENABLE_BIT];
    assign frac_m_o = (div_r[uart_ext_pkg::FBD_M_MSB:uart_ext_pkg::FBD_M_LSB] == 2'h0)
                    ? uart_ext_pkg::FRAC_M_ZERO_VALUE
                    : {1'b0, div_r[uart_ext_pkg::FBD_M_MSB:uart_ext_pkg::FBD_M_LSB]};
    assign frac_n_o = div_r[uart_ext_pkg::FBD_N_MSB:0];
    assign scratch_o = scratch_r;
    assign network_mode_o   = nec_r[uart_ext_pkg::NEC_MODE_BIT];
    assign parity_disable_o = network_mode_o;
    assign nine_bit_tx_o    = network_mode_o & nec_r[uart_ext_pkg::NEC_TX9_BIT];
    assign nine_bit_rx_o    = network_mode_o & nec_r[uart_ext_pkg::NEC_RX9_BIT];
    // word length bit is honoured as is; keeping tx9 off is software's job
    assign nine_bit_word_o  = nec_r[uart_ext_pkg::NEC_WORD9_BIT];
    assign tx_ninth_bit_o   = nine_bit_tx_o & nec_r[uart_ext_pkg::NEC_MARKER_BIT];
    assign serial_out_pin_o    = tx_serial_i;
    assign serial_out_pin_oe_o = nec_r[uart_ext_pkg::NEC_DRIVE_BIT];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    logic        wr_ctl;
    logic        wr_div;
    assign wr_ctl = acc_wr & hit(paddr_i, uart_ext_pkg::ADDR_NETWORK_ENABLE_CONTROL);
    assign wr_div = acc_wr & hit(paddr_i, uart_ext_pkg::ADDR_FRACTIONAL_BAUD_DIVIDER);

    chk_level_view: assert property (
        setup_rd && hit(paddr_i, uart_ext_pkg::ADDR_MODEM_LINE_STATUS) |=> prdata_o[7:4] == $past(lvl_r))
        else $error("modem levels wrong");
    chk_carrier_delta: assert property (
        $changed(lvl_r[3]) |-> mflag_r[3])
        else $error("carrier delta lost");
    chk_flag_hold: assert property (
        mflag_r[3] && !rd_mls |=> mflag_r[3])
        else $error("carrier delta dropped early");
    chk_ring_rise: assert property (
        $rose(lvl_r[2]) |-> mflag_r[2])
        else $error("ring rise lost");
    chk_ring_fall: assert property (
        $fell(lvl_r[2]) && !$past(mflag_r[2]) |-> !mflag_r[2])
        else $error("ring fall flagged");
    chk_ring_hold: assert property (
        mflag_r[2] && !rd_mls |=> mflag_r[2])
        else $error("ring flag dropped early");
    chk_ready_delta: assert property (
        $changed(lvl_r[1]) |-> mflag_r[1])
        else $error("set ready delta lost");
    chk_ready_clear: assert property (
        rd_mls && prdata_r[1] && !evt[1] |=> !mflag_r[1])
        else $error("set ready delta not cleared");
    chk_cts_delta: assert property (
        $changed(lvl_r[0]) |-> mflag_r[0])
        else $error("cts delta lost");
    chk_flag_clear: assert property (
        rd_mls && prdata_r[0] && !evt[0] |=> !mflag_r[0])
        else $error("delta not cleared by read");
    chk_read_race: assert property (
        rd_mls && evt[3] |=> mflag_r[3])
        else $error("change lost during read");
    chk_scratch_rw: assert property (
        acc_wr && hit(paddr_i, uart_ext_pkg::ADDR_SCRATCH_BYTE) |=> scratch_o == $past(pwdata_i[7:0]))
        else $error("scratch write lost");
    chk_frac_sel: assert property (
        wr_div |=> frac_baud_enable_o == $past(pwdata_i[uart_ext_pkg::FBD_ENABLE_BIT]))
        else $error("fractional select wrong");
    chk_m_zero: assert property (
        div_r[12:11] == 2'h0 |-> frac_m_o == 3'h4)
        else $error("m zero not four");
    chk_n_field: assert property (
        wr_div |=> frac_n_o == $past(pwdata_i[uart_ext_pkg::FBD_N_MSB:0]))
        else $error("n field wrong");
    chk_mode_write: assert property (
        wr_ctl |=> network_mode_o == $past(pwdata_i[uart_ext_pkg::NEC_MODE_BIT]))
        else $error("network mode wrong");
    chk_parity_off: assert property (
        network_mode_o |-> parity_disable_o)
        else $error("parity left on in network mode");
    chk_addr_mark: assert property (
        wr_ctl && pwdata_i[uart_ext_pkg::NEC_MODE_BIT] && pwdata_i[uart_ext_pkg::NEC_TX9_BIT]
        |=> tx_ninth_bit_o == $past(pwdata_i[uart_ext_pkg::NEC_MARKER_BIT])) else $error("address marker wrong");
    chk_net_gate: assert property (
        !network_mode_o |-> !nine_bit_tx_o && !nine_bit_rx_o && !parity_disable_o)
        else $error("network features without mode");
    chk_tx9_write: assert property (
        wr_ctl |=> nine_bit_tx_o == $past(&pwdata_i[uart_ext_pkg::NEC_MODE_BIT:uart_ext_pkg::NEC_TX9_BIT]))
        else $error("nine bit transmit wrong");
    chk_rx9_write: assert property (
        wr_ctl |=> nine_bit_rx_o == $past(pwdata_i[uart_ext_pkg::NEC_MODE_BIT] & pwdata_i[uart_ext_pkg::NEC_RX9_BIT]))
        else $error("nine bit receive wrong");
    chk_word_write: assert property (
        wr_ctl |=> nine_bit_word_o == $past(pwdata_i[uart_ext_pkg::NEC_WORD9_BIT]))
        else $error("word length wrong");
    chk_pin_drive: assert property (
        wr_ctl |=> serial_out_pin_oe_o == $past(pwdata_i[uart_ext_pkg::NEC_DRIVE_BIT]))
        else $error("pin drive wrong");
    chk_net_pend: assert property (
        net_evt |=> net_pend_r)
        else $error("address interrupt lost");
    chk_net_quiet: assert property (
        !nec_r[uart_ext_pkg::NEC_IRQ_EN_BIT] |-> !net_irq_o)
        else $error("network interrupt not gated");
    chk_ident_top: assert property (
        rd_iid |-> prdata_o[7:4] == 4'h0 && prdata_o[0] == !$past(net_pend_r))
        else $error("ident value wrong");
    chk_ident_idle: assert property (
        rd_iid && !$past(net_pend_r) |-> prdata_o[7:0] == uart_ext_pkg::RST_NETWORK_INTERRUPT_IDENT)
        else $error("idle ident wrong");

    // ------------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------------
    cov_ring_rise: cover property ($rose(lvl_r[2]) ##[1:20] rd_mls);
    cov_net_irq:   cover property (net_evt ##1 net_irq_o);
    cov_irq_out:   cover property (irq_o ##[1:10] !irq_o);
    cov_read_race: cover property (rd_mls && |evt);
    cov_addr_mark: cover property (wr_ctl ##1 tx_ninth_bit_o);
endmodule : uart_modem_network_ext
`default_nettype wire

// File: verification/modem_node_model.sv
// far-side node: modem status lines and received network characters
`default_nettype none
module modem_node_model (
    input  wire logic mclk_i,
    output logic      carrier_o,
    output logic      ring_o,
    output logic      set_ready_o,
    output logic      clear_to_send_o,
    output logic      char_valid_o,
    output logic      ninth_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {carrier_o, ring_o, set_ready_o, clear_to_send_o} = 4'h0;
        char_valid_o = 1'b0;
        ninth_o      = 1'b0;
    end
    // ------------------------------------------------------------------
    // modem lines, order carrier, ring, set ready, clear to send
    // ------------------------------------------------------------------
    task automatic set_lines(input logic [3:0] v);
        @(posedge mclk_i);
        {carrier_o, ring_o, set_ready_o, clear_to_send_o} <= v;
    endtask : set_lines
    // ------------------------------------------------------------------
    // one received character; ninth bit marks an address
    // ------------------------------------------------------------------
    task automatic send_char(input logic ninth);
        @(posedge mclk_i);
        char_valid_o <= 1'b1;
        ninth_o      <= ninth;
        @(posedge mclk_i);
        char_valid_o <= 1'b0;
        // line not held after the pulse, so show the inverse
        ninth_o      <= ~ninth;
    endtask : send_char
endmodule : modem_node_model
`default_nettype wire

// File: verification/uart_modem_network_ext_tb_top.sv
// self-checking bench for the modem and network extension registers
`default_nettype none
module uart_modem_network_ext_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    localparam logic [31:0] A_STS = uart_ext_pkg::ADDR_MODEM_LINE_STATUS;
    localparam logic [31:0] A_SCR = uart_ext_pkg::ADDR_SCRATCH_BYTE;
    localparam logic [31:0] A_CTL = uart_ext_pkg::ADDR_NETWORK_ENABLE_CONTROL;
    localparam logic [31:0] A_IID = uart_ext_pkg::ADDR_NETWORK_INTERRUPT_IDENT;
    localparam logic [31:0] A_DIV = uart_ext_pkg::ADDR_FRACTIONAL_BAUD_DIVIDER;
    localparam logic [31:0] A_IST = uart_ext_pkg::ADDR_IRQ_STATUS;
    localparam logic [31:0] A_IMK = uart_ext_pkg::ADDR_IRQ_MASK;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tx_ser = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, dcd, ri, dsr, cts, rxv, rx9b;
    logic        serial_out_pin, soe, frac_baud_enable, net, pdis, tx9, rx9, w9, ninth, nirq, irq;
    logic [2:0]  fm;
    logic [10:0] fn;
    logic [7:0]  scr;
    int          mismatches = 0, total_checks = 0, cycles = 0;
    always #25 mclk_i = ~mclk_i;
    uart_modem_network_ext uart_modem_network_ext_i (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .carrier_detect_i(dcd), .ring_indicator_i(ri), .set_ready_i(dsr), .clear_to_send_i(cts),
        .tx_serial_i(tx_ser), .rx_char_valid_i(rxv), .rx_ninth_bit_i(rx9b), .serial_out_pin_o(serial_out_pin),
        .serial_out_pin_oe_o(soe), .frac_baud_enable_o(frac_baud_enable), .frac_m_o(fm), .frac_n_o(fn),
        .scratch_o(scr), .network_mode_o(net), .parity_disable_o(pdis), .nine_bit_tx_o(tx9),
        .nine_bit_rx_o(rx9), .nine_bit_word_o(w9), .tx_ninth_bit_o(ninth), .net_irq_o(nirq), .irq_o(irq));
    modem_node_model modem_node_model_i (
        .mclk_i(mclk_i), .carrier_o(dcd), .ring_o(ri), .set_ready_o(dsr), .clear_to_send_o(cts),
        .char_valid_o(rxv), .ninth_o(rx9b));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        do @(posedge mclk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : settle
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_values();
        rdc(A_STS, 32'h00);
        rdc(A_SCR, 32'h00);
        rdc(A_CTL, 32'h04);
        rdc(A_IID, 32'h01);
        rdc(A_DIV, 32'h0000);
        chk(32'(soe), 32'h1);
    endtask : t_reset_values
    task automatic t_scratch_divider();
        wr(A_SCR, 32'hffff_ffa5);
        rdc(A_SCR, 32'ha5);
        chk(32'(scr), 32'ha5);
        wr(A_DIV, 32'hffff);
        rdc(A_DIV, 32'h9fff);
        chk({frac_baud_enable, 1'b0, fm, fn}, {1'b1, 1'b0, 3'h3, 11'h7ff});
        wr(A_DIV, 32'h0001);
        settle(1);
        chk({frac_baud_enable, fm, fn}, {1'b0, 3'h4, 11'h001});
    endtask : t_scratch_divider
    task automatic t_modem();
        wr(A_IMK, 32'h1);
        modem_node_model_i.set_lines(4'hf);
        settle(6);
        chk(32'(irq), 32'h1);
        rdc(A_STS, 32'hff);
        rdc(A_STS, 32'hf0);
        rdc(A_IST, 32'h1);
        wr(A_IMK, 32'h0);
        settle(1);
        chk(32'(irq), 32'h0);
        wr(A_IST, 32'h1);
        rdc(A_IST, 32'h0);
        wr(A_IMK, 32'h1);
        // ring falling edge must leave its flag clear
        modem_node_model_i.set_lines(4'h0);
        settle(6);
        rdc(A_STS, 32'h0b);
        rdc(A_STS, 32'h00);
        wr(A_IST, 32'h1);
        settle(1);
        chk(32'(irq), 32'h0);
    endtask : t_modem
    task automatic t_network();
        wr(A_CTL, 32'he7);
        settle(1);
        chk({net, pdis, tx9, rx9, ninth, soe}, 6'h3f);
        wr(A_CTL, 32'he6);
        settle(1);
        chk({net, pdis, ninth}, 3'h6);
        wr(A_CTL, 32'h60);
        settle(1);
        chk({net, pdis, tx9, rx9, soe}, 5'h00);
        wr(A_CTL, 32'h88);
        settle(1);
        chk({net, tx9, w9}, 3'h5);
        wr(A_CTL, 32'h04);
        tx_ser <= 1'b1;
        settle(1);
        chk({soe, serial_out_pin}, 2'h3);
        @(posedge mclk_i);
        tx_ser <= 1'b0;
        settle(1);
        chk({soe, serial_out_pin}, 2'h2);
        rdc(A_CTL, 32'h04);
    endtask : t_network
    task automatic t_rx_irq();
        wr(A_IMK, 32'h2);
        wr(A_CTL, 32'hb2);
        modem_node_model_i.send_char(1'b0);
        settle(2);
        chk({nirq, irq}, 2'h0);
        modem_node_model_i.send_char(1'b1);
        settle(2);
        chk({nirq, irq}, 2'h3);
        rdc(A_IID, 32'h06);
        rdc(A_IID, 32'h01);
        settle(1);
        chk(32'(nirq), 32'h0);
        wr(A_IST, 32'h2);
        wr(A_CTL, 32'ha2);
        modem_node_model_i.send_char(1'b1);
        settle(2);
        chk({nirq, irq}, 2'h0);
        rdc(A_IID, 32'h06);
        rdc(A_IST, 32'h0);
    endtask : t_rx_irq
    task automatic t_refused();
        wr(A_IID, 32'hff);
        rdc(A_IID, 32'h01);
        bus(1'b0, 32'hffff_0730, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        wr(32'hffff_0730, 32'h55);
        chk(32'(err), 32'h1);
        rdc(A_SCR, 32'ha5);
    endtask : t_refused
    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    // cycle budget well above the roughly 160 cycles the run needs
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_reset_values();
        t_scratch_divider();
        t_modem();
        t_network();
        t_rx_irq();
        t_refused();
        finish_test();
    end
endmodule : uart_modem_network_ext_tb_top
`default_nettype wire
